// [verilog/mtc_pkg.sv]
// shared constants and types for the translation control block
package mtc_pkg;
  localparam int MTC_VA_W = 32;
  localparam int MTC_PA_W = 31;
  localparam int MTC_ENTRIES = 32;
  // address space identifiers
  localparam logic [7:0] MTC_ASI_TLB_DIAG = 8'h06;
  localparam logic [7:0] MTC_ASI_USR_INSN = 8'h08;
  localparam logic [7:0] MTC_ASI_SUP_INSN = 8'h09;
  localparam logic [7:0] MTC_ASI_USR_DATA = 8'h0a;
  localparam logic [7:0] MTC_ASI_SUP_DATA = 8'h0b;
  localparam logic [7:0] MTC_ASI_BYPASS = 8'h20;
  // boot physical region values for pa[30:28]
  localparam logic [2:0] MTC_BOOT_FLASH = 3'h2;
  localparam logic [2:0] MTC_BOOT_PCI = 3'h3;
  // diagnostic offsets
  localparam logic [11:0] MTC_OFF_PAGE_WORD = 12'h000;
  localparam logic [11:0] MTC_OFF_LOWER_TAG = 12'h100;
  localparam logic [11:0] MTC_OFF_UPPER_TAG = 12'h300;
  localparam logic [11:0] MTC_OFF_LAST = 12'h07c;
  // bit positions, masks and the all-zero word
  localparam int MTC_BANK_BIT = 25;
  localparam int MTC_PCR_SOFT_WALK = 23;
  localparam int MTC_PCR_PAGE_DIS = 22;
  localparam int MTC_LT_PTP = 0;
  localparam int MTC_LT_MOD = 2;
  localparam logic [9:0] MTC_LT_MASK = 10'h3f5;
  localparam logic [3:0] MTC_UT_VALID_BIT = 4'h8;
  localparam logic [31:0] MTC_ZERO_WORD = 32'h00000000;
  // access size code for a word
  localparam logic [1:0] MTC_SIZE_WORD = 2'h2;
  localparam logic [2:0] MTC_FAULT_LEVEL = 3'h7;
  localparam logic [3:0] MTC_IRQ_LEVEL = 4'hf;
  typedef enum logic [1:0] {
    MTC_SRC_NONE = 2'b00,
    MTC_SRC_WALK = 2'b01,
    MTC_SRC_DATA = 2'b10,
    MTC_SRC_FETCH = 2'b11
  } mtc_src_e;
  typedef enum logic [2:0] {
    MTC_REQ_NOP = 3'b000,
    MTC_REQ_READ_TWO_WORDS = 3'b001,
    MTC_REQ_RD128 = 3'b010,
    MTC_REQ_RD256 = 3'b011,
    MTC_REQ_WR8 = 3'b100,
    MTC_REQ_WR16 = 3'b101,
    MTC_REQ_WR32 = 3'b110,
    MTC_REQ_WR64 = 3'b111
  } mtc_req_e;
  typedef enum logic [1:0] {
    MTC_TW_NONE = 2'b00,
    MTC_TW_FETCH = 2'b01,
    MTC_TW_DATA = 2'b10
  } mtc_tw_e;
endpackage

// [verilog/mtc_page_hit.sv]
// even/odd bank page-hit registers for dram page mode
`timescale 1ns/1ps
`default_nettype none
module mtc_page_hit import mtc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // request
  input wire logic issue,
  input wire logic [MTC_PA_W-1:0] phys_addr,
  input wire logic disable_page,
  // result
  output logic page_hit
);
  logic [18:0] page_r [2];
  logic [18:0] page_nxt [2];
  logic [1:0] valid_r;
  logic [1:0] valid_nxt;
  logic bank;

  assign bank = phys_addr[MTC_BANK_BIT];
  always_comb begin
    page_nxt = page_r;
    valid_nxt = valid_r;
    if (issue) begin
      page_nxt[bank] = phys_addr[30:12];
      valid_nxt[bank] = 1'b1;
    end
    page_hit = !disable_page && valid_r[bank] &&
      (page_r[bank] == phys_addr[30:12]);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      valid_r <= 2'b00;
      page_r[0] <= 19'h00000;
      page_r[1] <= 19'h00000;
    end else begin
      valid_r <= valid_nxt;
      page_r <= page_nxt;
    end
  end
endmodule
`default_nettype wire

// [verilog/mtc_breakpoint.sv]
// lab breakpoint matcher, configured through scan
`timescale 1ns/1ps
`default_nettype none
module mtc_breakpoint import mtc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // scan configuration
  input wire logic [31:0] bp_va_value,
  input wire logic [31:0] bp_va_mask,
  input wire logic [3:0] bp_va_qual,
  input wire logic bp_req_en,
  input wire logic [2:0] bp_req_type,
  input wire logic bp_tw_en,
  input wire logic [1:0] bp_tw_type,
  input wire logic bp_lvl_en,
  input wire logic [1:0] bp_tw_level,
  // observed activity
  input wire logic [31:0] va,
  input wire logic fetch_valid_decode,
  input wire logic data_read_wb,
  input wire logic data_write_wb,
  input wire logic data_atomic_wb,
  input wire logic mem_req_issue_strobe,
  input wire logic [2:0] req_type,
  input wire logic [1:0] walk_type,
  input wire logic [1:0] walk_level,
  // clock stop
  output logic stop_clocks
);
  logic va_hit;
  logic req_hit;
  logic stop_nxt;

  always_comb begin
    va_hit = (((va ^ bp_va_value) & bp_va_mask) == MTC_ZERO_WORD) &&
      ((bp_va_qual[0] && fetch_valid_decode) ||
       (bp_va_qual[1] && data_read_wb) ||
       (bp_va_qual[2] && data_write_wb) ||
       (bp_va_qual[3] && data_atomic_wb));
    req_hit = bp_req_en && mem_req_issue_strobe &&
      (req_type == bp_req_type) &&
      (!bp_tw_en || walk_type == bp_tw_type) &&
      (!bp_lvl_en || walk_level == bp_tw_level);
    // sticky so the stop holds until reset re-arms it
    stop_nxt = stop_clocks || (va_hit && bp_va_qual != 4'h0) || req_hit;
  end

  always_ff @(posedge core_clk) begin
    if (reset) stop_clocks <= 1'b0;
    else stop_clocks <= stop_nxt;
  end
endmodule
`default_nettype wire

// [verilog/mtc_translate.sv]
// translation control: arbitration, pa select, tlb, diag and faults
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module mtc_translate import mtc_pkg::*; #(
  parameter int ENTRIES = MTC_ENTRIES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control state
  input wire logic [31:0] processor_control_reg,
  input wire logic [7:0] context_reg,
  input wire logic mmu_enable,
  input wire logic boot_mode,
  input wire logic boot_from_pci,
  // table walk and r/m update requests
  input wire logic walk_req,
  input wire logic [MTC_PA_W-1:0] walk_phys_addr,
  input wire logic walk_fault,
  // data reference
  input wire logic data_req,
  input wire logic [31:0] data_va,
  input wire logic [7:0] data_asi,
  input wire logic data_write,
  input wire logic data_super,
  input wire logic [1:0] data_size,
  input wire logic [31:0] data_wdata,
  input wire logic data_bus_error,
  // instruction fetch
  input wire logic fetch_req,
  input wire logic [31:0] fetch_va,
  input wire logic fetch_super,
  input wire logic fetch_bus_error,
  // flush and async fault
  input wire logic flush_req,
  input wire logic flush_page_only,
  input wire logic async_fault,
  // breakpoint scan setup and observation
  input wire logic [31:0] bp_va_value,
  input wire logic [31:0] bp_va_mask,
  input wire logic [3:0] bp_va_qual,
  input wire logic bp_req_en,
  input wire logic [2:0] bp_req_type,
  input wire logic bp_tw_en,
  input wire logic [1:0] bp_tw_type,
  input wire logic bp_lvl_en,
  input wire logic [1:0] bp_tw_level,
  input wire logic fetch_valid_decode,
  input wire logic data_read_wb,
  input wire logic data_write_wb,
  input wire logic data_atomic_wb,
  input wire logic [2:0] req_type,
  input wire logic [1:0] walk_level,
  // memory controller side
  output logic mem_req_issue_strobe,
  output logic [MTC_PA_W-1:0] current_phys_addr,
  output logic page_mode,
  output logic [1:0] grant_src,
  output logic walk_start,
  output logic [1:0] walk_type,
  // integer unit side
  output logic [31:0] diag_rdata,
  output logic diag_ack,
  output logic internal_error,
  output logic insn_access_error,
  output logic insn_access_exception,
  output logic data_access_error,
  output logic data_access_exception,
  output logic insn_mmu_miss,
  output logic data_mmu_miss,
  output logic [3:0] ext_irq_level,
  output logic stop_clocks
);
  ////////////////////////////////////////////////////////////////////
  // tlb storage
  logic [31:0] pte_r [ENTRIES];
  logic [9:0] ltag_r [ENTRIES];
  logic [31:0] utag_r [ENTRIES];
  logic [31:0] pte_nxt [ENTRIES];
  logic [9:0] ltag_nxt [ENTRIES];
  logic [31:0] utag_nxt [ENTRIES];

  // upper tag: vtag[31:12] ctx[11:4] valid[3] level[2:0]
  function automatic logic tag_match(input logic [31:0] ut,
    input logic [31:0] va, input logic [7:0] ctx);
    logic m;
    m = ut[3] && (ut[11:4] == ctx);
    if (ut[2]) m = m && (ut[31:24] == va[31:24]);
    if (ut[1]) m = m && (ut[23:18] == va[23:18]);
    if (ut[0]) m = m && (ut[17:12] == va[17:12]);
    return m;
  endfunction

  function automatic logic in_space(input logic [7:0] asi,
    input logic [7:0] a, input logic [7:0] b);
    return (asi == a) || (asi == b);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // arbitration and address select
  mtc_src_e src;
  logic [31:0] sel_va;
  logic [7:0] sel_asi;
  logic sel_super;
  logic sel_write;
  logic hit;
  logic [4:0] hit_idx;
  logic needs_tlb;
  logic [MTC_PA_W-1:0] pa;
  logic perm_ok;
  logic is_diag;

  always_comb begin
    src = MTC_SRC_NONE;
    sel_va = fetch_va;
    sel_asi = fetch_super ? MTC_ASI_SUP_INSN : MTC_ASI_USR_INSN;
    sel_super = fetch_super;
    sel_write = 1'b0;
    is_diag = data_req && data_asi == MTC_ASI_TLB_DIAG;
    if (walk_req) begin
      src = MTC_SRC_WALK;
    end else if (data_req && !is_diag) begin
      src = MTC_SRC_DATA;
      sel_va = data_va;
      sel_asi = data_asi;
      sel_super = data_super;
      sel_write = data_write;
    end else if (fetch_req) begin
      src = MTC_SRC_FETCH;
    end
    hit = 1'b0;
    hit_idx = 5'h00;
    for (int i = 0; i < ENTRIES; i++) begin
      if (!hit && !ltag_r[i][MTC_LT_PTP] &&
          tag_match(utag_r[i], sel_va, context_reg)) begin
        hit = 1'b1;
        hit_idx = 5'(i);
      end
    end
    needs_tlb = 1'b0;
    pa = sel_va[30:0];
    if (src == MTC_SRC_WALK) begin
      pa = walk_phys_addr;
    end else if (sel_asi == MTC_ASI_BYPASS) begin
      pa = sel_va[30:0];
    end else if (boot_mode && src == MTC_SRC_FETCH &&
        in_space(sel_asi, MTC_ASI_USR_INSN, MTC_ASI_SUP_INSN)) begin
      pa = {boot_from_pci ? MTC_BOOT_PCI : MTC_BOOT_FLASH,
        sel_va[27:0]};
    end else if (!mmu_enable) begin
      pa = sel_va[30:0];
    end else begin
      needs_tlb = 1'b1;
      pa = {pte_r[hit_idx][26:8], sel_va[11:0]};
    end
    // lower tag: ue ur uw se sr sw at bits 9..4, modified at bit 2
    perm_ok = sel_super ?
      (src == MTC_SRC_FETCH ? ltag_r[hit_idx][6] :
       sel_write ? ltag_r[hit_idx][4] : ltag_r[hit_idx][5]) :
      (src == MTC_SRC_FETCH ? ltag_r[hit_idx][9] :
       sel_write ? ltag_r[hit_idx][7] : ltag_r[hit_idx][8]);
  end

  ////////////////////////////////////////////////////////////////////
  // diagnostic access and tlb updates
  logic [11:0] diag_off;
  logic [4:0] diag_idx;
  logic [1:0] diag_region;
  logic diag_ok;
  logic [31:0] rdata_nxt;

  always_comb begin
    diag_off = {data_va[11:7], 7'h00};
    diag_idx = data_va[6:2];
    diag_region = 2'h3;
    if (data_va[31:12] == 20'h00000 && data_va[1:0] == 2'h0) begin
      if (diag_off == MTC_OFF_PAGE_WORD) diag_region = 2'h0;
      else if (diag_off == MTC_OFF_LOWER_TAG) diag_region = 2'h1;
      else if (diag_off == MTC_OFF_UPPER_TAG) diag_region = 2'h2;
    end
    diag_ok = is_diag && data_size == MTC_SIZE_WORD;
    pte_nxt = pte_r;
    ltag_nxt = ltag_r;
    utag_nxt = utag_r;
    rdata_nxt = MTC_ZERO_WORD;
    case (diag_region)
      2'h0: rdata_nxt = pte_r[diag_idx];
      2'h1: rdata_nxt = {22'h000000, ltag_r[diag_idx] & MTC_LT_MASK |
        {9'h000, ltag_r[diag_idx][MTC_LT_PTP]}};
      2'h2: rdata_nxt = utag_r[diag_idx];
      default: rdata_nxt = MTC_ZERO_WORD;
    endcase
    if (diag_ok && data_write) begin
      case (diag_region)
        2'h0: pte_nxt[diag_idx] = data_wdata;
        2'h1: ltag_nxt[diag_idx] = data_wdata[9:0] & MTC_LT_MASK |
          {9'h000, data_wdata[MTC_LT_PTP]};
        2'h2: utag_nxt[diag_idx] = data_wdata;
        default: ;
      endcase
    end
    // stores to a clean page mark the entry modified
    if (src == MTC_SRC_DATA && needs_tlb && hit && sel_write && perm_ok)
      ltag_nxt[hit_idx][MTC_LT_MOD] = 1'b1;
    if (flush_req) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (!flush_page_only && ltag_r[i][MTC_LT_PTP])
          utag_nxt[i][3] = 1'b0;
        else if (!flush_page_only)
          utag_nxt[i][3] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < ENTRIES; i++) begin
        pte_r[i] <= MTC_ZERO_WORD;
        ltag_r[i] <= 10'h000;
        utag_r[i] <= MTC_ZERO_WORD;
      end
    end else begin
      pte_r <= pte_nxt;
      ltag_r <= ltag_nxt;
      utag_r <= utag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs and fault reporting
  logic miss;
  logic soft_walk_enable;
  logic hit_page;

  assign soft_walk_enable = processor_control_reg[MTC_PCR_SOFT_WALK];
  assign miss = needs_tlb && !hit && src != MTC_SRC_NONE &&
    src != MTC_SRC_WALK;

  mtc_page_hit u_page (
    .core_clk(core_clk),
    .reset(reset),
    .issue(src != MTC_SRC_NONE && !miss),
    .phys_addr(pa),
    .disable_page(processor_control_reg[MTC_PCR_PAGE_DIS]),
    .page_hit(hit_page)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_req_issue_strobe <= 1'b0;
      current_phys_addr <= 31'h00000000;
      page_mode <= 1'b0;
      grant_src <= MTC_SRC_NONE;
      walk_start <= 1'b0;
      walk_type <= MTC_TW_NONE;
      diag_rdata <= MTC_ZERO_WORD;
      diag_ack <= 1'b0;
      internal_error <= 1'b0;
      insn_access_error <= 1'b0;
      insn_access_exception <= 1'b0;
      data_access_error <= 1'b0;
      data_access_exception <= 1'b0;
      insn_mmu_miss <= 1'b0;
      data_mmu_miss <= 1'b0;
      ext_irq_level <= 4'h0;
    end else begin
      mem_req_issue_strobe <= src != MTC_SRC_NONE && !miss;
      current_phys_addr <= pa;
      page_mode <= hit_page;
      grant_src <= src;
      walk_start <= miss && !soft_walk_enable;
      walk_type <= !miss || soft_walk_enable ? MTC_TW_NONE :
        src == MTC_SRC_DATA ? MTC_TW_DATA : MTC_TW_FETCH;
      diag_rdata <= rdata_nxt;
      diag_ack <= diag_ok;
      internal_error <= is_diag && !diag_ok;
      insn_access_error <= fetch_bus_error;
      data_access_error <= data_bus_error;
      insn_access_exception <= src == MTC_SRC_FETCH && needs_tlb &&
        hit && !perm_ok;
      data_access_exception <= (src == MTC_SRC_DATA && needs_tlb &&
        hit && !perm_ok) || walk_fault;
      insn_mmu_miss <= miss && soft_walk_enable &&
        src == MTC_SRC_FETCH;
      data_mmu_miss <= miss && soft_walk_enable &&
        src == MTC_SRC_DATA;
      // the interrupt controller decides whether level 15 reaches the core
      ext_irq_level <= async_fault ? MTC_IRQ_LEVEL : 4'h0;
    end
  end

  mtc_breakpoint u_bp (
    .core_clk(core_clk),
    .reset(reset),
    .bp_va_value(bp_va_value),
    .bp_va_mask(bp_va_mask),
    .bp_va_qual(bp_va_qual),
    .bp_req_en(bp_req_en),
    .bp_req_type(bp_req_type),
    .bp_tw_en(bp_tw_en),
    .bp_tw_type(bp_tw_type),
    .bp_lvl_en(bp_lvl_en),
    .bp_tw_level(bp_tw_level),
    .va(sel_va),
    .fetch_valid_decode(fetch_valid_decode),
    .data_read_wb(data_read_wb),
    .data_write_wb(data_write_wb),
    .data_atomic_wb(data_atomic_wb),
    .mem_req_issue_strobe(mem_req_issue_strobe),
    .req_type(req_type),
    .walk_type(walk_type),
    .walk_level(walk_level),
    .stop_clocks(stop_clocks)
  );
endmodule
`default_nettype wire

// [tb/mtc_translate_asserts.sv]
// concurrent checks on the translation control block ports
`timescale 1ns/1ps
`default_nettype none
module mtc_translate_asserts import mtc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // watched inputs
  input wire logic [31:0] processor_control_reg,
  input wire logic mmu_enable,
  input wire logic boot_mode,
  input wire logic boot_from_pci,
  input wire logic walk_req,
  input wire logic [MTC_PA_W-1:0] walk_phys_addr,
  input wire logic data_req,
  input wire logic [31:0] data_va,
  input wire logic [7:0] data_asi,
  input wire logic [1:0] data_size,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_va,
  input wire logic async_fault,
  // watched outputs
  input wire logic [MTC_PA_W-1:0] current_phys_addr,
  input wire logic page_mode,
  input wire logic [1:0] grant_src,
  input wire logic diag_ack,
  input wire logic internal_error,
  input wire logic [3:0] ext_irq_level,
  input wire logic stop_clocks
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic fo;
  assign fo = fetch_req && !data_req && !walk_req;
  ////////////////////////////////////////////////////////////////////////
  a_walk_first: assert property (
    walk_req |=> grant_src == 2'h1 &&
    current_phys_addr == $past(walk_phys_addr))
    else $error("walk request not served first");
  a_data_second: assert property (
    !walk_req && data_req && data_asi == MTC_ASI_BYPASS |=>
    grant_src == 2'h2 && current_phys_addr == $past(data_va[30:0]))
    else $error("bypass data reference lost");
  a_fetch_last: assert property (
    fo && !mmu_enable |=> grant_src == 2'h3)
    else $error("lone fetch not granted");
  a_boot_fetch: assert property (
    fo && boot_mode |=> current_phys_addr == {$past(boot_from_pci) ?
    MTC_BOOT_PCI : MTC_BOOT_FLASH, $past(fetch_va[27:0])})
    else $error("boot fetch address wrong");
  a_pass_fetch: assert property (
    fo && !boot_mode && !mmu_enable |=>
    current_phys_addr == $past(fetch_va[30:0]))
    else $error("pass through address wrong");
  a_diag_size: assert property (
    !walk_req && data_req && data_asi == MTC_ASI_TLB_DIAG &&
    data_size != MTC_SIZE_WORD |=> internal_error && !diag_ack)
    else $error("odd size diag access not refused");
  a_irq_level: assert property (
    async_fault |=> ext_irq_level == MTC_IRQ_LEVEL)
    else $error("fault interrupt level wrong");
  a_stop_sticky: assert property (
    stop_clocks |=> stop_clocks [*3])
    else $error("clock stop dropped");
  a_page_off: assert property (
    processor_control_reg[MTC_PCR_PAGE_DIS] |=> !page_mode)
    else $error("page mode while disabled");
  a_page_empty: assert property (
    $fell(reset) |-> !page_mode ##1 !page_mode)
    else $error("page hit right after reset");
  ////////////////////////////////////////////////////////////////////////
  c_all_pending: cover property (walk_req && data_req && fetch_req);
  c_page_hit: cover property (page_mode);
  c_diag_refused: cover property (internal_error);
  c_stopped: cover property (stop_clocks);
endmodule
bind mtc_translate mtc_translate_asserts u_chk (.*);
`default_nettype wire

// [tb/mtc_mem_model.sv]
// memory controller side: tracks dram pages to predict page mode
`timescale 1ns/1ps
`default_nettype none
module mtc_mem_model import mtc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // from the block
  input wire logic issue,
  input wire logic [MTC_PA_W-1:0] pa,
  input wire logic page_dis,
  // prediction
  output logic exp_page,
  output logic [15:0] issue_cnt
);
  logic [18:0] page_r [2];
  logic [1:0] valid_r;
  logic dis_r;
  logic bank;
  ////////////////////////////////////////////////////////////////////////
  assign bank = pa[MTC_BANK_BIT];
  // no valid page until a bank is first used
  assign exp_page = valid_r[bank] && page_r[bank] == pa[30:12] && !dis_r;
  always_ff @(posedge core_clk) begin
    dis_r <= page_dis;
    if (reset) begin
      valid_r <= 2'h0;
      issue_cnt <= 16'h0;
    end else if (issue) begin
      valid_r[bank] <= 1'b1;
      page_r[bank] <= pa[30:12];
      issue_cnt <= issue_cnt + 16'h1;
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the translation control block
`timescale 1ns/1ps
`default_nettype none
module tb import mtc_pkg::*;;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] processor_control_reg, data_va, data_wdata, fetch_va;
  logic [31:0] bp_va_value, bp_va_mask, diag_rdata;
  logic [7:0] context_reg, data_asi;
  logic mmu_enable, boot_mode, boot_from_pci, walk_req, walk_fault, data_req;
  logic data_write, data_super, data_bus_error, fetch_req, fetch_super;
  logic fetch_bus_error, flush_req, flush_page_only, async_fault, bp_req_en;
  logic bp_tw_en, bp_lvl_en, fetch_valid_decode, data_read_wb, data_write_wb;
  logic data_atomic_wb, mem_req_issue_strobe, page_mode, walk_start;
  logic diag_ack, internal_error, insn_access_error, insn_access_exception;
  logic data_access_error, data_access_exception, insn_mmu_miss;
  logic data_mmu_miss, stop_clocks, exp_page;
  logic [MTC_PA_W-1:0] walk_phys_addr, current_phys_addr;
  logic [1:0] data_size, bp_tw_type, bp_tw_level, walk_level, grant_src;
  logic [1:0] walk_type;
  logic [3:0] bp_va_qual, ext_irq_level;
  logic [2:0] bp_req_type, req_type;
  logic [15:0] issue_cnt;
  int failures = 0;
  int checks = 0;
  mtc_translate #(.ENTRIES(32)) dut (.*);
  mtc_mem_model u_mem (.core_clk, .reset, .issue(mem_req_issue_strobe),
    .pa(current_phys_addr),
    .page_dis(processor_control_reg[MTC_PCR_PAGE_DIS]),
    .exp_page, .issue_cnt);
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // walk address is derived from va so one task serves every source
  task automatic op(input logic w, d, f, input logic [7:0] asi,
      input logic [31:0] va, wd, input logic [1:0] sz, input logic wr);
    @(posedge core_clk);
    walk_req <= w;
    walk_phys_addr <= ~va[30:0];
    data_req <= d;
    fetch_req <= f;
    data_asi <= asi;
    data_va <= va;
    fetch_va <= va;
    data_wdata <= wd;
    data_size <= sz;
    data_write <= wr;
    @(posedge core_clk);
    walk_req <= 1'b0;
    data_req <= 1'b0;
    fetch_req <= 1'b0;
    #1;
  endtask
  task automatic byp(input logic [31:0] va);
    op('0, '1, '0, MTC_ASI_BYPASS, va, '0, 2'h2, '0);
  endtask
  task automatic dg(input logic [31:0] va, wd, input logic [1:0] sz,
      input logic wr);
    op('0, '1, '0, MTC_ASI_TLB_DIAG, va, wd, sz, wr);
  endtask
  task automatic xd();
    op('0, '1, '0, MTC_ASI_SUP_DATA, 32'h12345abc, '0, 2'h2, '0);
  endtask
  // every issued access is judged against the page model
  always @(negedge core_clk) begin
    if (!reset && mem_req_issue_strobe === 1'b1)
      chk("page_mode", 32'(page_mode), 32'(exp_page));
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic t_page();
    byp(32'h02001000);
    chk("first page", 32'(page_mode), 32'h0);
    byp(32'h02001000);
    chk("same page", 32'(page_mode), 32'h1);
    byp(32'h00005000);
    chk("even bank", 32'(page_mode), 32'h0);
    byp(32'h02001004);
    chk("odd kept", 32'(page_mode), 32'h1);
    @(posedge core_clk);
    processor_control_reg <= 32'h00400000;
    byp(32'h02001004);
    chk("disabled", 32'(page_mode), 32'h0);
    @(posedge core_clk);
    processor_control_reg <= '0;
    #1;
    chk("issued", 32'(issue_cnt), 32'h5);
  endtask
  task automatic t_prio();
    op('1, '1, '1, MTC_ASI_BYPASS, 32'h1234, '0, 2'h2, '0);
    chk("grant", 32'(grant_src), 32'h1);
    chk("walk pa", 32'(current_phys_addr), 32'h7fffedcb);
    op('0, '1, '1, MTC_ASI_BYPASS, 32'h1234, '0, 2'h2, '0);
    chk("grant", 32'(grant_src), 32'h2);
    op('0, '0, '1, 8'h0, 32'h1234, '0, 2'h2, '0);
    chk("grant", 32'(grant_src), 32'h3);
  endtask
  task automatic t_modes();
    logic [7:0] asis [3] = '{MTC_ASI_USR_INSN, MTC_ASI_USR_DATA,
      MTC_ASI_SUP_DATA};
    for (int b = 0; b < 2; b++) begin
      @(posedge core_clk);
      boot_mode <= 1'b1;
      boot_from_pci <= b[0];
      op('0, '0, '1, 8'h0, 32'hfedcba98, '0, 2'h2, '0);
      chk("boot", 32'(current_phys_addr), {3'h1, b[0], 28'hedcba98});
      byp(32'hfedcba98);
      chk("bypass", 32'(current_phys_addr), 32'h7edcba98);
    end
    @(posedge core_clk);
    boot_mode <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      op('0, '1, '0, asis[i], 32'hfedcba98, '0, 2'h2, '0);
      chk("pass", 32'(current_phys_addr), 32'h7edcba98);
    end
  endtask
  task automatic t_diag();
    logic [31:0] offs [4] = '{32'h7c, 32'h37c, 32'h80, 32'h180};
    logic [31:0] vals [4] = '{32'h5a5a5a02, 32'h5a5a5a50, 32'h0, 32'h0};
    for (int i = 0; i < 4; i++) begin
      dg(offs[i], i < 2 ? vals[i] : '1, 2'h2, '1);
      dg(offs[i], '0, 2'h2, '0);
      chk("diag read", diag_rdata, vals[i]);
      chk("diag ack", 32'(diag_ack), 32'h1);
    end
    dg(32'h104, '1, 2'h2, '1);
    dg(32'h104, '0, 2'h2, '0);
    chk("lower tag", diag_rdata, 32'h3f5);
    dg(32'h7c, '0, 2'h1, '1);
    chk("size error", 32'(internal_error), 32'h1);
    chk("no ack", 32'(diag_ack), 32'h0);
    dg(32'h7c, '0, 2'h2, '0);
    chk("not written", diag_rdata, 32'h5a5a5a02);
  endtask
  task automatic t_xlate();
    @(posedge core_clk);
    context_reg <= 8'h05;
    mmu_enable <= 1'b1;
    // a single entry, so no two entries map one page
    dg(32'h300, 32'h1234505f, 2'h2, '1);
    dg(32'h100, 32'h3f4, 2'h2, '1);
    dg(32'h0, 32'h02a55a02, 2'h2, '1);
    xd();
    chk("xlate pa", 32'(current_phys_addr), 32'h2a55aabc);
    chk("hit", 32'(mem_req_issue_strobe), 32'h1);
    dg(32'h100, 32'h384, 2'h2, '1);
    xd();
    chk("data perm", 32'(data_access_exception), 32'h1);
    op('0, '0, '1, 8'h0, 32'h12345abc, '0, 2'h2, '0);
    chk("fetch perm", 32'(insn_access_exception), 32'h1);
    @(posedge core_clk);
    context_reg <= 8'h06;
    xd();
    chk("ctx miss", 32'(walk_start), 32'h1);
    chk("walk type", 32'(walk_type), 32'h2);
    @(posedge core_clk);
    processor_control_reg <= 32'h00800000;
    xd();
    chk("data trap", 32'(data_mmu_miss), 32'h1);
    chk("no walk", 32'(walk_start), 32'h0);
    op('0, '0, '1, 8'h0, 32'h12345abc, '0, 2'h2, '0);
    chk("fetch trap", 32'(insn_mmu_miss), 32'h1);
    @(posedge core_clk);
    processor_control_reg <= '0;
    context_reg <= 8'h05;
    @(posedge core_clk);
    flush_req <= 1'b1;
    @(posedge core_clk);
    flush_req <= 1'b0;
    xd();
    chk("flushed", 32'(walk_start), 32'h1);
    @(posedge core_clk);
    mmu_enable <= 1'b0;
  endtask
  task automatic t_err();
    @(posedge core_clk);
    data_bus_error <= 1'b1;
    fetch_bus_error <= 1'b1;
    async_fault <= 1'b1;
    byp(32'h40);
    chk("data err", 32'(data_access_error), 32'h1);
    chk("irq", 32'(ext_irq_level), 32'hf);
    op('0, '0, '1, 8'h0, 32'h40, '0, 2'h2, '0);
    chk("fetch err", 32'(insn_access_error), 32'h1);
    @(posedge core_clk);
    data_bus_error <= 1'b0;
    fetch_bus_error <= 1'b0;
    async_fault <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("irq off", 32'(ext_irq_level), 32'h0);
  endtask
  // clock stop is sticky, so this runs last
  task automatic t_bp();
    @(posedge core_clk);
    bp_req_en <= 1'b1;
    bp_req_type <= MTC_REQ_WR32;
    req_type <= MTC_REQ_WR32;
    repeat (4) @(posedge core_clk);
    #1;
    chk("idle stop", 32'(stop_clocks), 32'h0);
    byp(32'h40);
    for (int i = 0; i < 4 && stop_clocks !== 1'b1; i++) @(posedge core_clk);
    #1;
    chk("stop", 32'(stop_clocks), 32'h1);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    bp_va_value <= 32'h40;
    bp_va_mask <= '1;
    bp_va_qual <= 4'h1;
    fetch_valid_decode <= 1'b1;
    #1;
    chk("rearmed", 32'(stop_clocks), 32'h0);
    @(posedge core_clk);
    #1;
    chk("va stop", 32'(stop_clocks), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {processor_control_reg, data_va, data_wdata, fetch_va, bp_va_value,
     bp_va_mask, context_reg, data_asi, mmu_enable, boot_mode, boot_from_pci,
     walk_req, walk_fault, data_req, data_write, data_bus_error, fetch_req,
     fetch_bus_error, flush_req, flush_page_only, async_fault, bp_req_en,
     bp_tw_en, bp_lvl_en, fetch_valid_decode, data_read_wb, data_write_wb,
     data_atomic_wb, walk_phys_addr, data_size, bp_tw_type, bp_tw_level,
     walk_level, bp_va_qual, bp_req_type, req_type} = '0;
    data_super = 1'b1;
    fetch_super = 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_page();
    t_prio();
    t_modes();
    t_diag();
    t_xlate();
    t_err();
    t_bp();
    results();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    results();
  end
endmodule
`default_nettype wire
